// file: design/prc_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * pressure reference conditioning block.
 * Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
 */
`ifndef PRC_REGS_VH
`define PRC_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PRC_CTRL_OFS      8'h00
`define PRC_SCALE_OFS     8'h04
`define PRC_BIAS_OFS      8'h08
`define PRC_THRESH_OFS    8'h0C
`define PRC_RAMP_UP_OFS   8'h10
`define PRC_RAMP_DN_OFS   8'h14
`define PRC_STATUS_OFS    8'h18
`define PRC_REF_OFS       8'h1C
`define PRC_LIN_OFS       8'h20
`define PRC_PID_OFS       8'h24

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PRC_CTRL_GRAY     0
`define PRC_CTRL_BUS_SEL  1
`define PRC_CTRL_RAMP_EN  2
`define PRC_CTRL_RAMP_DUAL 3
`define PRC_CTRL_TR_MA    4
`define PRC_CTRL_FAIL_OL  5
`define PRC_CTRL_LIN_EN   6
`define PRC_CTRL_BUS_REF  7
`define PRC_CTRL_SET_LO   8
`define PRC_CTRL_RESET    16'h0010

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define PRC_SCALE_RESET   16'hFFFF
`define PRC_BIAS_RESET    16'h0000
`define PRC_THRESH_RESET  16'h0000
`define PRC_RAMP_RESET    16'h0001
`define PRC_TRANS_LOW     16'h0CCD
`define PRC_TRANS_HIGH    16'hFD70
`define PRC_TICK_NS       1000
`define PRC_CLK_NS        25
`define PRC_TICK_CYC      ((`PRC_TICK_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)
`define PRC_LIN_POINTS    16

`endif

// file: design/prc_lin_mem.v
/*
 * Linearization table: sixteen 16-bit breakpoints, registered read port.
 * Assumes a single clock; writes and reads are on the same edge domain.
 */
module prc_lin_mem (
	input  wire        clk_in,
	input  wire        we_in,
	input  wire [3:0]  waddr_in,
	input  wire [15:0] wdata_in,
	input  wire [3:0]  raddr_in,
	output reg  [15:0] rdata_out
);
	reg [15:0] mem [0:15];

	// ----------------------------------------------------------------
	// Write port and registered read
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
		rdata_out <= mem[raddr_in];
	end
endmodule

// file: design/prc_top.v
/*
 * Pressure reference conditioning: set select, scale, bias, ramp,
 * linearization and transducer failure reaction, Wishbone registers.
 * Assumes select and enable pins are asynchronous; analog samples arrive
 * already digitised in the clk_in domain.
 */
`include "prc_regs.vh"
module prc_top (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire [31:0] wb_adr_in,
	input  wire [31:0] wb_dat_in,
	input  wire [3:0]  wb_sel_in,
	input  wire        wb_we_in,
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out,
	input  wire        pid_select_bit0,
	input  wire        pid_select_bit1,
	input  wire        enable_in,
	input  wire [15:0] analog_ref_in,
	input  wire [15:0] transducer_feedback_in,
	input  wire        ext_fault_in,
	output reg  [15:0] current_cmd_out,
	output reg  [15:0] setpoint_out,
	output reg  [1:0]  active_set_out,
	output reg         open_loop_set,
	output reg         fault_n_out
);
	localparam integer TICK_INT = `PRC_TICK_CYC;
	localparam [15:0]  TICK_CYC = TICK_INT[15:0];

	reg  [15:0] ctrl;
	reg  [15:0] scale;
	reg  [15:0] bias;
	reg  [15:0] thresh;
	reg  [15:0] ramp_up;
	reg  [15:0] ramp_dn;
	reg  [15:0] bus_ref;
	reg  [1:0]  s0_meta;
	reg  [1:0]  s0_sync;
	reg  [1:0]  en_meta;
	reg         en_sync;
	reg         sel_valid;
	reg  [15:0] tick_cnt;
	reg         tick;
	reg  [15:0] ramp_val;
	reg         tr_fail;
	reg  [1:0]  pin_set;
	reg  [1:0]  next_set;
	reg  [15:0] ref_src;
	reg  [16:0] biased;
	reg  [15:0] target;
	reg  [31:0] scaled;
	reg  [16:0] step_up;
	reg  [16:0] step_dn;
	reg  [31:0] rd_mux;
	wire        wb_req;
	wire        wb_wr;
	wire [7:0]  wb_ofs;
	wire        lin_we;
	wire [15:0] lin_q;
	wire        cut_current;

	// Bus decode; a request is taken only while ack is low
	assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign wb_wr  = wb_req & wb_we_in & wb_sel_in[0] & wb_sel_in[1];
	assign wb_ofs = wb_adr_in[7:0];
	assign lin_we = wb_wr && (wb_ofs == `PRC_LIN_OFS);

	// ----------------------------------------------------------------
	// Linearization table
	// ----------------------------------------------------------------
	// table write path
	prc_lin_mem u_lin (
		.clk_in    (clk_in),
		.we_in     (lin_we),
		.waddr_in  (wb_dat_in[19:16]),
		.wdata_in  (wb_dat_in[15:0]),
		.raddr_in  (target[15:12]),
		.rdata_out (lin_q)
	);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// two-flop select sync
	always @(posedge clk_in) begin
		if (rst_in) begin
			s0_meta   <= 2'h0;
			s0_sync   <= 2'h0;
			en_meta   <= 2'h0;
			en_sync   <= 1'b0;
			sel_valid <= 1'b0;
		end else begin
			s0_meta   <= {pid_select_bit1, pid_select_bit0};
			s0_sync   <= s0_meta;
			en_meta   <= {en_meta[0], enable_in};
			en_sync   <= en_meta[1];
			sel_valid <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Set decode
	// ----------------------------------------------------------------
	always @* begin
		pin_set = s0_sync;
		if (ctrl[`PRC_CTRL_GRAY]) begin
			pin_set = {s0_sync[1], s0_sync[1] ^ s0_sync[0]};
		end
		if (ctrl[`PRC_CTRL_BUS_SEL]) begin
			next_set = ctrl[`PRC_CTRL_SET_LO+1:`PRC_CTRL_SET_LO];
		end else if (sel_valid) begin
			next_set = pin_set;
		end else begin
			next_set = 2'h0;
		end
		if (tr_fail && ctrl[`PRC_CTRL_FAIL_OL]) begin
			next_set = 2'h3;
		end
	end

	// ----------------------------------------------------------------
	// Reference path: source, bias, scale
	// ----------------------------------------------------------------
	always @* begin
		ref_src = ctrl[`PRC_CTRL_BUS_REF] ? bus_ref : analog_ref_in;
		if (ref_src > thresh) begin
			biased = {1'b0, ref_src} + {1'b0, bias};
		end else begin
			biased = {1'b0, ref_src};
		end
		target = biased[16] ? 16'hFFFF : biased[15:0];
		scaled = target * scale;
	end

	// ----------------------------------------------------------------
	// Ramp tick divider
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (rst_in) begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b0;
		end else if (tick_cnt >= TICK_CYC - 16'h0001) begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Ramp generator
	// ----------------------------------------------------------------
	// Candidate steps; bit 16 catches a wrap past either end
	always @* begin
		step_up = {1'b0, ramp_val} + {1'b0, ramp_up};
		step_dn = {1'b0, ramp_val} - {1'b0, (ctrl[`PRC_CTRL_RAMP_DUAL] ? ramp_dn : ramp_up)};
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			ramp_val <= 16'h0000;
		end else if (!ctrl[`PRC_CTRL_RAMP_EN]) begin
			ramp_val <= scaled[31:16];
		end else if (tick) begin
			// stepwise approach
			// Clamped at the target so it never overshoots
			if (ramp_val < scaled[31:16]) begin
				ramp_val <= (step_up[16] || step_up[15:0] > scaled[31:16]) ?
					scaled[31:16] : step_up[15:0];
			end else if (ramp_val > scaled[31:16]) begin
				// A borrow means the step went below zero
				ramp_val <= (step_dn[16] || step_dn[15:0] < scaled[31:16]) ?
					scaled[31:16] : step_dn[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Transducer failure detection
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (rst_in) begin
			tr_fail <= 1'b0;
		end else begin
			tr_fail <= ctrl[`PRC_CTRL_TR_MA] &&
				((transducer_feedback_in < `PRC_TRANS_LOW) || (transducer_feedback_in > `PRC_TRANS_HIGH));
		end
	end

	assign cut_current = tr_fail && !ctrl[`PRC_CTRL_FAIL_OL];

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (rst_in) begin
			current_cmd_out <= 16'h0000;
			setpoint_out    <= 16'h0000;
			active_set_out  <= 2'h0;
			open_loop_set   <= 1'b0;
			fault_n_out     <= 1'b1;
		end else begin
			active_set_out <= next_set;
			open_loop_set  <= (next_set == 2'h3);
			current_cmd_out <= (en_sync && !cut_current) ? ramp_val : 16'h0000;
			setpoint_out <= ctrl[`PRC_CTRL_LIN_EN] ? lin_q : target;
			fault_n_out <= !(tr_fail || ext_fault_in);
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	always @* begin
		case (wb_ofs)
			`PRC_CTRL_OFS:    rd_mux = {16'h0000, ctrl};
			`PRC_SCALE_OFS:   rd_mux = {16'h0000, scale};
			`PRC_BIAS_OFS:    rd_mux = {16'h0000, bias};
			`PRC_THRESH_OFS:  rd_mux = {16'h0000, thresh};
			`PRC_RAMP_UP_OFS: rd_mux = {16'h0000, ramp_up};
			`PRC_RAMP_DN_OFS: rd_mux = {16'h0000, ramp_dn};
			`PRC_STATUS_OFS:  rd_mux = {26'h0, !fault_n_out, tr_fail, open_loop_set, en_sync, active_set_out};
			`PRC_REF_OFS:     rd_mux = {16'h0000, bus_ref};
			`PRC_PID_OFS:     rd_mux = {16'h0000, ramp_val};
			default:          rd_mux = 32'h00000000;
		endcase
	end

	// Writes need both low byte lanes; narrower writes are ignored
	always @(posedge clk_in) begin
		if (rst_in) begin
			ctrl       <= `PRC_CTRL_RESET;
			scale      <= `PRC_SCALE_RESET;
			bias       <= `PRC_BIAS_RESET;
			thresh     <= `PRC_THRESH_RESET;
			ramp_up    <= `PRC_RAMP_RESET;
			ramp_dn    <= `PRC_RAMP_RESET;
			bus_ref    <= 16'h0000;
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_req;
			if (wb_req) begin
				wb_dat_out <= rd_mux;
			end
			if (wb_wr) begin
				case (wb_ofs)
					`PRC_CTRL_OFS:    ctrl    <= wb_dat_in[15:0];
					`PRC_SCALE_OFS:   scale   <= wb_dat_in[15:0];
					`PRC_BIAS_OFS:    bias    <= wb_dat_in[15:0];
					`PRC_THRESH_OFS:  thresh  <= wb_dat_in[15:0];
					`PRC_RAMP_UP_OFS: ramp_up <= wb_dat_in[15:0];
					`PRC_RAMP_DN_OFS: ramp_dn <= wb_dat_in[15:0];
					`PRC_REF_OFS:     bus_ref <= wb_dat_in[15:0];
					default:          ;
				endcase
			end
		end
	end
endmodule

// file: tb/prc_top_chk.sv
/* Port checker for prc_top, bound into the design.
   Assumes one clock and a synchronous active-high reset. */
module prc_chk (
	input wire        clk_in,
	input wire        rst_in,
	input wire        wb_cyc_in,
	input wire        wb_stb_in,
	input wire        wb_ack_out,
	input wire        enable_in,
	input wire        ext_fault_in,
	input wire [15:0] current_cmd_out,
	input wire [1:0]  active_set_out,
	input wire        open_loop_set,
	input wire        fault_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ----------------------------------------------------------------
	// Sequences and properties
	// ----------------------------------------------------------------
	sequence s_take;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	// Five samples cover the enable synchroniser and the output flop
	sequence s_off;
		!enable_in [*5];
	endsequence
	AST_ACK_ONE: assert property (s_take |=> wb_ack_out) else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
	AST_IDLE: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out) else $error("stray ack");
	AST_OPEN_LOOP: assert property (open_loop_set == (active_set_out == 2'h3)) else $error("loop");
	AST_RESET_SET: assert property ($past(rst_in) |-> active_set_out == 2'h0) else $error("set");
	AST_RESET_FAULT: assert property ($past(rst_in) |-> fault_n_out) else $error("reset fault");
	AST_XFAULT: assert property (ext_fault_in |-> ##[1:2] !fault_n_out) else $error("fault");
	AST_ENABLE_CUT: assert property (s_off |-> current_cmd_out == 16'h0000) else $error("en");
endmodule
bind prc_top prc_chk prc_chk_i (.clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .enable_in,
	.ext_fault_in, .current_cmd_out, .active_set_out, .open_loop_set, .fault_n_out);

// file: tb/prc_plc_model.sv
/* Control unit stand-in: drives set pins and the reference.
   Assumes bench commands change just after a rising edge. */
module prc_plc_model (
	input  wire         clk_in,
	input  wire  [1:0]  set_code_in,
	input  wire  [15:0] ref_in,
	output logic        pid_select_bit0,
	output logic        pid_select_bit1,
	output logic [15:0] analog_ref_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pins low at power-up, like an unpowered output stage
	initial begin
		pid_select_bit0 = 1'h0;
		pid_select_bit1 = 1'h0;
		analog_ref_out = 16'h0000;
	end
	always @(posedge clk_in) begin
		pid_select_bit0 <= set_code_in[0];
		pid_select_bit1 <= set_code_in[1];
		analog_ref_out <= ref_in;
	end
endmodule

// file: tb/prc_top_bench.sv
/* Self-checking bench for prc_top.
   Assumes the checker is bound and the model drives the pins. */
module prc_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in = 1'h0, rst_in = 1'h1, wb_we_in = 1'h0, wb_cyc_in = 1'h0, wb_stb_in = 1'h0;
	logic        enable_in = 1'h0, ext_fault_in = 1'h0;
	logic [31:0] wb_adr_in = 32'h0, wb_dat_in = 32'h0, rdat;
	logic [3:0]  wb_sel_in = 4'hF;
	logic [1:0]  set_code_in = 2'h0, e2;
	logic [15:0] ref_in = 16'h0, transducer_feedback_in = 16'h8000, sc, bi, th, r;
	wire  [31:0] wb_dat_out;
	wire         wb_ack_out, pid_select_bit0, pid_select_bit1, open_loop_set, fault_n_out;
	wire  [15:0] analog_ref_in, current_cmd_out, setpoint_out;
	wire  [1:0]  active_set_out;
	integer      bad_count = 0, n_tests = 0, seed = 92, i, k;
	localparam logic [39:0] RT [4] = '{{8'h00, 32'h10}, {8'h04, 32'hFFFF}, {8'h10, 32'h1}, {8'h3C, 32'h0}};
	always #12.5 clk_in = ~clk_in;
	prc_top prc_top_i (.clk_in, .rst_in, .wb_adr_in, .wb_dat_in, .wb_sel_in, .wb_we_in, .wb_cyc_in,
		.wb_stb_in, .wb_dat_out, .wb_ack_out, .pid_select_bit0, .pid_select_bit1, .enable_in,
		.analog_ref_in, .transducer_feedback_in, .ext_fault_in, .current_cmd_out, .setpoint_out,
		.active_set_out, .open_loop_set, .fault_n_out);
	prc_plc_model prc_plc_model_i (.clk_in, .set_code_in, .ref_in, .pid_select_bit0, .pid_select_bit1,
		.analog_ref_out(analog_ref_in));
	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task finish_test;
		$display("checks %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task report(input [31:0] g, input [31:0] e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_reg(input [31:0] g, input [31:0] e);
		report(g, e);
	endtask
	task chk_pin(input [15:0] g, input [15:0] e);
		report({16'h0, g}, {16'h0, e});
	endtask
	// Classic single cycle; hold until ack is seen at an edge
	task wb(input [7:0] a, input w, input [31:0] d);
		wb_adr_in <= {24'h0, a};
		wb_we_in <= w;
		wb_dat_in <= d;
		wb_cyc_in <= 1'h1;
		wb_stb_in <= 1'h1;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (wb_ack_out !== 1'h1 && k < 20);
		if (wb_ack_out !== 1'h1) begin
			bad_count++;
			finish_test;
		end
		rdat = wb_dat_out;
		wb_cyc_in <= 1'h0;
		wb_stb_in <= 1'h0;
		@(posedge clk_in);
	endtask
	function [15:0] pick(input [1:0] s);
		case (s)
			2'h0: pick = current_cmd_out;
			2'h1: pick = {14'h0, active_set_out};
			2'h2: pick = {15'h0, fault_n_out};
			default: pick = {15'h0, open_loop_set};
		endcase
	endfunction
	// Bounded wait for an output, then compare; a miss ends the run
	task wait_eq(input [1:0] s, input [15:0] e, input integer n);
		k = 0;
		while (pick(s) !== e && k < n) begin
			@(posedge clk_in);
			k++;
		end
		chk_pin(pick(s), e);
		if (k >= n && pick(s) !== e) finish_test;
	endtask
	function [15:0] exp_cur(input [15:0] rr, input [15:0] t, input [15:0] b, input [15:0] s);
		logic [16:0] v;
		logic [31:0] m;
		v = (rr > t) ? rr + b : {1'h0, rr};
		if (v[16]) v = 17'h0FFFF;
		m = v[15:0] * s;
		exp_cur = m[31:16];
	endfunction
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'h0;
		for (i = 0; i < 4; i++) begin
			wb(RT[i][39:32], 1'h0, 32'h0);
			chk_reg(rdat, RT[i][31:0]);
		end
		wait_eq(1, 16'h0, 20);
		enable_in <= 1'h1;
		// Binary codes, then Gray codes
		for (i = 0; i < 8; i++) begin
			if (i == 4) wb(8'h00, 1'h1, 32'h11);
			set_code_in <= i[1:0];
			@(posedge clk_in);
			e2 = (i < 4) ? i[1:0] : {i[1], i[1] ^ i[0]};
			wait_eq(1, {14'h0, e2}, 20);
			wait_eq(3, {15'h0, e2 == 2'h3}, 5);
		end
		for (i = 0; i < 4; i++) begin
			wb(8'h00, 1'h1, {22'h0, i[1:0], 8'h12});
			wait_eq(1, i[15:0], 20);
		end
		wb(8'h00, 1'h1, 32'h10);
		// Random scale, bias and threshold with corner cases
		for (i = 0; i < 8; i++) begin
			{sc, bi} = $random(seed);
			{th, r} = $random(seed);
			if (i == 0) th = r;
			if (i == 1) {th, bi} = {16'h0, 16'hFFFF};
			wb(8'h04, 1'h1, {16'h0, sc});
			wb(8'h08, 1'h1, {16'h0, bi});
			wb(8'h0C, 1'h1, {16'h0, th});
			ref_in <= r;
			@(posedge clk_in);
			wait_eq(0, exp_cur(r, th, bi, sc), 20);
		end
		wb(8'h04, 1'h1, 32'hFFFF);
		wb(8'h0C, 1'h1, 32'h0);
		wb(8'h08, 1'h1, 32'h0);
		ref_in <= 16'h8000;
		set_code_in <= 2'h0;
		transducer_feedback_in <= 16'h0100;
		wait_eq(2, 16'h0, 20);
		wait_eq(0, 16'h0, 20);
		enable_in <= 1'h0;
		repeat (8) @(posedge clk_in);
		chk_pin({15'h0, fault_n_out}, 16'h0);
		enable_in <= 1'h1;
		wb(8'h00, 1'h1, 32'h30);
		wait_eq(1, 16'h3, 20);
		wait_eq(0, 16'h7FFF, 20);
		wb(8'h00, 1'h1, 32'h00);
		wait_eq(2, 16'h1, 20);
		transducer_feedback_in <= 16'h8000;
		wb(8'h00, 1'h1, 32'h10);
		ext_fault_in <= 1'h1;
		@(posedge clk_in);
		ext_fault_in <= 1'h0;
		@(posedge clk_in);
		chk_pin({15'h0, fault_n_out}, 16'h0);
		wait_eq(2, 16'h1, 20);
		enable_in <= 1'h0;
		wait_eq(0, 16'h0, 20);
		// Ramp value keeps following the reference while disabled
		wb(8'h24, 1'h0, 32'h0);
		chk_reg(rdat, 32'h7FFF);
		enable_in <= 1'h1;
		ref_in <= 16'h0;
		wait_eq(0, 16'h0, 20);
		// Bus reference with zero threshold, bias still added above it
		wb(8'h0C, 1'h1, 32'h0);
		wb(8'h08, 1'h1, 32'h0100);
		wb(8'h1C, 1'h1, 32'h4000);
		wb(8'h00, 1'h1, 32'h90);
		wait_eq(0, exp_cur(16'h4000, 16'h0, 16'h0100, 16'hFFFF), 20);
		wb(8'h00, 1'h1, 32'h10);
		wb(8'h08, 1'h1, 32'h0);
		// Table point 4 holds 0x1234; reference 0x4567 lands on it
		wb(8'h20, 1'h1, 32'h00041234);
		ref_in <= 16'h4567;
		repeat (4) @(posedge clk_in);
		chk_pin(setpoint_out, 16'h4567);
		wb(8'h00, 1'h1, 32'h50);
		repeat (2) @(posedge clk_in);
		chk_pin(setpoint_out, 16'h1234);
		wb(8'h00, 1'h1, 32'h10);
		ref_in <= 16'h0;
		wait_eq(0, 16'h0, 20);
		// Ramps: rising at one rate, falling at a slower one
		wb(8'h10, 1'h1, 32'h0800);
		wb(8'h14, 1'h1, 32'h0400);
		wb(8'h00, 1'h1, 32'h1C);
		ref_in <= 16'h8000;
		repeat (40) @(posedge clk_in);
		chk_pin({15'h0, current_cmd_out < 16'h7FFF}, 16'h1);
		wait_eq(0, 16'h7FFF, 2000);
		ref_in <= 16'h0;
		wait_eq(0, 16'h0, 2000);
		chk_pin({15'h0, k > 1000}, 16'h1);
		// Single rate: the fall uses the rise step, so it is quicker
		wb(8'h00, 1'h1, 32'h14);
		ref_in <= 16'h8000;
		wait_eq(0, 16'h7FFF, 2000);
		ref_in <= 16'h0;
		wait_eq(0, 16'h0, 2000);
		chk_pin({15'h0, k < 1000}, 16'h1);
		// Mid-run reset with set 4 on the pins: set 1 until resampled
		set_code_in <= 2'h3;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'h1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'h0;
		@(posedge clk_in);
		chk_pin({14'h0, active_set_out}, 16'h0);
		@(posedge clk_in);
		chk_pin({14'h0, active_set_out}, 16'h0);
		wait_eq(1, 16'h3, 20);
		wb(8'h00, 1'h0, 32'h0);
		chk_reg(rdat, 32'h10);
		finish_test;
	end
endmodule
